/* File: src/asc_pkg.sv */
// Package for the converter sequence start control block
package asc_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] ASC_ADDR_SEQ_CTRL = 8'h05;
    localparam logic [7:0] ASC_ADDR_ROLLOVER = 8'h00;
    localparam logic [7:0] ASC_ADDR_SEQ_LEN = 8'h01;
    localparam logic [7:0] ASC_ADDR_TRIG = 8'h02;
    localparam logic [7:0] ASC_ADDR_STATUS = 8'h03;
    localparam logic [7:0] ASC_CTRL_RESET = 8'h00;
    localparam logic [3:0] ASC_CHAN_ZERO = 4'h0;
    localparam logic [3:0] ASC_CHAN_SEVEN = 4'h7;
    localparam logic [3:0] ASC_LEN_RESET = 4'h4;
    localparam logic [3:0] ASC_WRAP_RESET = 4'hF;
    localparam logic [3:0] ASC_ONE4 = 4'h1;
    localparam logic [7:0] ASC_ZERO8 = 8'h00;

    // ------------------------------------------------------------
    // Control register layout
    // ------------------------------------------------------------
    typedef struct packed {
        logic spare;
        logic specialChannelEnable;
        logic continuousMode;
        logic channelSweepMode;
        logic [3:0] channelCode;
    } asc_ctrl_t;

    // Request towards the conversion core
    typedef struct packed {
        logic start;
        logic special;
        logic [3:0] channel;
    } asc_conv_t;

    typedef enum logic [2:0] {
        ASC_IDLE = 3'b001,
        ASC_ARMED = 3'b010,
        ASC_RUN = 3'b100
    } asc_state_t;
endpackage

/* File: src/asc_seq_start.sv */
// Start and channel sequencing control of the converter sequence controller
//
// Notes on behaviour
// - Any control write aborts the running sequence and starts afresh with new settings.
// - With external trigger on, one control write arms; then each trigger starts a sequence.
// - A start means the sampling phase of the first conversion begins.
// - Bit 6 enables special-channel conversion through the channel code.
// - Bit 5 picks one sequence or continuous back-to-back sequences.
// - With external trigger on, bit 5 is ignored; one sequence per trigger.
// - Sweep off: every sample uses the selected channel.
// - Sweep on: number of channels converted equals configured sequence length.
// - Sweep order: code, then plus one; after the wrap channel comes channel zero.
// - Starting above the wrap channel at a code of seven or less, the first wrap goes from seven to zero.
// - Bits 3 to 0 hold the channel code; sole channel in single mode.
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module asc_seq_start (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdData,
    // External trigger pin
    input wire logic extTrigger,
    // Conversion core handshake
    input wire logic convDone,
    output asc_pkg::asc_conv_t convReq,
    output logic seqActive,
    output logic seqComplete
);
    import asc_pkg::*;

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    asc_ctrl_t ctrl_reg, ctrl_next;
    logic [3:0] wrap_reg, wrap_next;
    logic [3:0] len_reg, len_next;
    logic trigEn_reg, trigEn_next;
    logic [7:0] rd_reg, rd_next;
    asc_state_t state_reg, state_next;
    logic [3:0] chan_reg, chan_next;
    logic [3:0] count_reg, count_next;
    logic firstWrap_reg, firstWrap_next;
    asc_conv_t conv_reg, conv_next;
    logic done_reg, done_next;
    logic trigS1_reg, trigS2_reg, trigS3_reg;
    logic trigEdge;
    logic ctrlWrite;

    // Next sweep channel
    function automatic logic [3:0] next_chan(input logic [3:0] c, input logic [3:0] w, input logic fw);
        logic [3:0] lim;
        lim = fw ? ASC_CHAN_SEVEN : w;
        if (c == lim) begin
            next_chan = ASC_CHAN_ZERO;
        end else begin
            next_chan = c + ASC_ONE4;
        end
    endfunction

    // ------------------------------------------------------------
    // Trigger synchroniser
    // ------------------------------------------------------------
    // Edge detect reads only the second and third stages
    always_ff @(posedge mclk) begin
        if (reset) begin
            trigS1_reg <= 1'b0;
            trigS2_reg <= 1'b0;
            trigS3_reg <= 1'b0;
        end else begin
            trigS1_reg <= extTrigger;
            trigS2_reg <= trigS1_reg;
            trigS3_reg <= trigS2_reg;
        end
    end
    assign trigEdge = trigS2_reg & ~trigS3_reg;
    assign ctrlWrite = regWrite && (regAddr == ASC_ADDR_SEQ_CTRL);

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    always_comb begin
        ctrl_next = ctrl_reg;
        wrap_next = wrap_reg;
        len_next = len_reg;
        trigEn_next = trigEn_reg;
        rd_next = ASC_ZERO8;
        if (regWrite) begin
            unique case (regAddr)
                ASC_ADDR_SEQ_CTRL: ctrl_next = asc_ctrl_t'(regWrData);
                ASC_ADDR_ROLLOVER: wrap_next = regWrData[3:0];
                ASC_ADDR_SEQ_LEN: len_next = regWrData[3:0];
                ASC_ADDR_TRIG: trigEn_next = regWrData[0];
                default: ;
            endcase
        end
        if (regRead) begin
            unique case (regAddr)
                ASC_ADDR_SEQ_CTRL: rd_next = ctrl_reg;
                ASC_ADDR_ROLLOVER: rd_next = {4'h0, wrap_reg};
                ASC_ADDR_SEQ_LEN: rd_next = {4'h0, len_reg};
                ASC_ADDR_TRIG: rd_next = {7'h00, trigEn_reg};
                ASC_ADDR_STATUS: rd_next = {count_reg, chan_reg};
                default: rd_next = ASC_ZERO8;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            ctrl_reg <= asc_ctrl_t'(ASC_CTRL_RESET);
            wrap_reg <= ASC_WRAP_RESET;
            len_reg <= ASC_LEN_RESET;
            trigEn_reg <= 1'b0;
            rd_reg <= ASC_ZERO8;
        end else begin
            ctrl_reg <= ctrl_next;
            wrap_reg <= wrap_next;
            len_reg <= len_next;
            trigEn_reg <= trigEn_next;
            rd_reg <= rd_next;
        end
    end
    assign regRdData = rd_reg;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    // A zero length is treated as one conversion
    logic [3:0] seqLen;
    assign seqLen = (len_reg == 4'h0) ? ASC_ONE4 : len_reg;

    always_comb begin
        state_next = state_reg;
        chan_next = chan_reg;
        count_next = count_reg;
        firstWrap_next = firstWrap_reg;
        conv_next = conv_reg;
        conv_next.start = 1'b0;
        done_next = 1'b0;
        if (ctrlWrite) begin
            // New settings take effect at once; running work is dropped
            conv_next.special = regWrData[6];
            chan_next = regWrData[3:0];
            count_next = ASC_CHAN_ZERO;
            firstWrap_next = regWrData[3:0] > wrap_reg;
            if (trigEn_reg) begin
                state_next = ASC_ARMED;
            end else begin
                state_next = ASC_RUN;
                conv_next.start = 1'b1;
                conv_next.channel = regWrData[3:0];
            end
        end else begin
            unique case (state_reg)
                ASC_IDLE: ;
                ASC_ARMED: begin
                    if (trigEdge) begin
                        state_next = ASC_RUN;
                        conv_next.start = 1'b1;
                        conv_next.channel = ctrl_reg.channelCode;
                        chan_next = ctrl_reg.channelCode;
                        count_next = ASC_CHAN_ZERO;
                        firstWrap_next = ctrl_reg.channelCode > wrap_reg;
                    end
                end
                ASC_RUN: begin
                    if (convDone) begin
                        if (count_reg + ASC_ONE4 >= seqLen) begin
                            done_next = 1'b1;
                            chan_next = ctrl_reg.channelCode;
                            count_next = ASC_CHAN_ZERO;
                            firstWrap_next = ctrl_reg.channelCode > wrap_reg;
                            if (trigEn_reg) begin
                                state_next = ASC_ARMED;
                            end else if (ctrl_reg.continuousMode) begin
                                conv_next.start = 1'b1;
                                conv_next.channel = ctrl_reg.channelCode;
                            end else begin
                                state_next = ASC_IDLE;
                            end
                        end else begin
                            count_next = count_reg + ASC_ONE4;
                            if (ctrl_reg.channelSweepMode) begin
                                chan_next = next_chan(chan_reg, wrap_reg, firstWrap_reg);
                                if (chan_reg == ASC_CHAN_SEVEN && firstWrap_reg) begin
                                    firstWrap_next = 1'b0;
                                end
                                conv_next.channel = chan_next;
                            end else begin
                                conv_next.channel = ctrl_reg.channelCode;
                            end
                            conv_next.start = 1'b1;
                        end
                    end
                end
                default: state_next = ASC_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            state_reg <= ASC_IDLE;
            chan_reg <= ASC_CHAN_ZERO;
            count_reg <= ASC_CHAN_ZERO;
            firstWrap_reg <= 1'b0;
            conv_reg <= '0;
            done_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            chan_reg <= chan_next;
            count_reg <= count_next;
            firstWrap_reg <= firstWrap_next;
            conv_reg <= conv_next;
            done_reg <= done_next;
        end
    end

    assign convReq = conv_reg;
    assign seqActive = state_reg[2];
    assign seqComplete = done_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_ctrl_write_untrig;
        ctrlWrite && !trigEn_reg;
    endsequence

    chk_write_restarts: assert property (@(posedge mclk) disable iff (reset)
        s_ctrl_write_untrig |=> convReq.start && seqActive && convReq.channel == $past(regWrData[3:0]))
        else $error("control write did not restart sequence");
    chk_arm_waits: assert property (@(posedge mclk) disable iff (reset)
        ctrlWrite && trigEn_reg |=> !convReq.start && state_reg == ASC_ARMED)
        else $error("armed write started without trigger");
    chk_trig_starts: assert property (@(posedge mclk) disable iff (reset)
        state_reg == ASC_ARMED && trigEdge && !ctrlWrite |=> convReq.start)
        else $error("trigger did not start sequence");
    chk_special_flag: assert property (@(posedge mclk) disable iff (reset)
        ctrlWrite |=> convReq.special == $past(regWrData[6]))
        else $error("special flag wrong");
    chk_single_stops: assert property (@(posedge mclk) disable iff (reset)
        seqComplete && !ctrl_reg.continuousMode && !trigEn_reg && !$past(ctrlWrite) |-> state_reg == ASC_IDLE)
        else $error("single sequence kept running");
    chk_trig_single: assert property (@(posedge mclk) disable iff (reset)
        seqComplete && trigEn_reg && !$past(ctrlWrite) |-> state_reg == ASC_ARMED && !convReq.start)
        else $error("triggered mode repeated sequence");
    chk_fixed_chan: assert property (@(posedge mclk) disable iff (reset)
        convReq.start && !ctrl_reg.channelSweepMode && !$past(ctrlWrite) |-> convReq.channel == ctrl_reg.channelCode)
        else $error("single channel mode changed channel");
    chk_len_count: assert property (@(posedge mclk) disable iff (reset)
        seqActive |-> count_reg < seqLen)
        else $error("sequence longer than configured");
    chk_sweep_wrap: assert property (@(posedge mclk) disable iff (reset)
        seqActive && convDone && !ctrlWrite && ctrl_reg.channelSweepMode && !firstWrap_reg
        && chan_reg == wrap_reg && count_reg + ASC_ONE4 < seqLen |=> chan_reg == ASC_CHAN_ZERO)
        else $error("sweep did not wrap to zero");
    chk_cont_restart: assert property (@(posedge mclk) disable iff (reset)
        seqComplete && ctrl_reg.continuousMode && !trigEn_reg && !$past(ctrlWrite) |-> convReq.start)
        else $error("continuous mode did not restart");

    // ------------------------------------------------------------
    // Sweep stepping checks
    // ------------------------------------------------------------
    // A conversion that is not the last of its sequence moves the sweep on
    sequence s_sweep_step;
        seqActive && convDone && !ctrlWrite && ctrl_reg.channelSweepMode && count_reg + ASC_ONE4 < seqLen;
    endsequence

    chk_sweep_step: assert property (@(posedge mclk) disable iff (reset)
        s_sweep_step ##0 (chan_reg != (firstWrap_reg ? ASC_CHAN_SEVEN : wrap_reg))
        |=> chan_reg == $past(chan_reg) + ASC_ONE4 && convReq.channel == chan_reg && convReq.start)
        else $error("sweep did not step to the next channel");
    chk_first_wrap: assert property (@(posedge mclk) disable iff (reset)
        s_sweep_step ##0 (firstWrap_reg && chan_reg == ASC_CHAN_SEVEN) |=> chan_reg == ASC_CHAN_ZERO && !firstWrap_reg)
        else $error("first wrap did not go from seven to zero");

    // ------------------------------------------------------------
    // Start and arming checks
    // ------------------------------------------------------------
    chk_start_pulse: assert property (@(posedge mclk) disable iff (reset)
        convReq.start && !ctrlWrite && !convDone |=> !convReq.start)
        else $error("sampling start held longer than one cycle");
    chk_armed_holds: assert property (@(posedge mclk) disable iff (reset)
        state_reg == ASC_ARMED && !trigEdge && !ctrlWrite |=> state_reg == ASC_ARMED && !convReq.start)
        else $error("armed controller moved without a trigger");
    chk_trig_chan: assert property (@(posedge mclk) disable iff (reset)
        state_reg == ASC_ARMED && trigEdge && !ctrlWrite |=> convReq.channel == ctrl_reg.channelCode && seqActive)
        else $error("trigger start used the wrong channel");
    chk_count_clear: assert property (@(posedge mclk) disable iff (reset)
        ctrlWrite |=> count_reg == ASC_CHAN_ZERO && !seqComplete)
        else $error("control write kept the old conversion count");
    chk_special_hold: assert property (@(posedge mclk) disable iff (reset)
        !ctrlWrite |=> $stable(convReq.special))
        else $error("special flag changed without a control write");
    chk_cont_chan: assert property (@(posedge mclk) disable iff (reset)
        seqComplete && ctrl_reg.continuousMode && !trigEn_reg && !$past(ctrlWrite)
        |-> convReq.channel == ctrl_reg.channelCode && count_reg == ASC_CHAN_ZERO)
        else $error("continuous restart did not reuse the settings");
endmodule // asc_seq_start

`default_nettype wire

/* File: tb/asc_core_model.sv */
// Behavioural conversion core answering sampling requests
`timescale 1ns/1ps
`default_nettype none

module asc_core_model (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Controller side
    input wire asc_pkg::asc_conv_t convReq,
    input wire logic abortReq,
    input wire logic [3:0] delay,
    output logic convDone
);
    import asc_pkg::*;
    logic busyReg;
    logic [3:0] cntReg;
    initial convDone = 1'b0;
    // An aborted conversion never reports, or it would be counted in the new sequence
    always @(posedge mclk) begin
        convDone <= 1'b0;
        if (reset || abortReq) begin
            busyReg <= 1'b0;
        end else if (convReq.start) begin
            busyReg <= 1'b1;
            cntReg <= delay;
        end else if (busyReg) begin
            if (cntReg <= 4'h1) begin
                convDone <= 1'b1;
                busyReg <= 1'b0;
            end else begin
                cntReg <= cntReg - 4'h1;
            end
        end
    end
endmodule // asc_core_model
`default_nettype wire

/* File: tb/asc_seq_start_tb_top.sv */
// Self-checking bench for the sequence start control block
`timescale 1ns/1ps
`default_nettype none

module asc_seq_start_tb_top;
    import asc_pkg::*;
    logic mclk, reset, regWrite, regRead, extTrigger, convDone, seqActive, seqComplete, abortReq;
    logic [7:0] regAddr, regWrData, regRdData, c;
    logic [3:0] delay;
    asc_conv_t convReq;
    int mismatches, check_count, cycles, seed, w, l;
    int expQ[$];
    logic expSpecial;
    assign abortReq = regWrite && (regAddr == ASC_ADDR_SEQ_CTRL);

    asc_seq_start i_asc_seq_start (.mclk(mclk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
        .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .extTrigger(extTrigger),
        .convDone(convDone), .convReq(convReq), .seqActive(seqActive), .seqComplete(seqComplete));
    asc_core_model i_asc_core_model (.mclk(mclk), .reset(reset), .convReq(convReq), .abortReq(abortReq),
        .delay(delay), .convDone(convDone));

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chkReq(input asc_conv_t got, input asc_conv_t exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        $display("checks=%0d mismatches=%0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic wrReg(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge mclk);
        regWrite <= 1'b0;
    endtask
    task automatic rdReg(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge mclk);
        regRead <= 1'b0;
        #1;
        chk8(regRdData, e);
    endtask
    // Reference channel order; start codes stay at or below seven
    task automatic pushSeq(input int code, input int wrap, input int len, input bit sweep);
        int ch;
        bit pend;
        ch = code;
        pend = code > wrap;
        for (int i = 0; i < ((len == 0) ? 1 : len); i++) begin
            expQ.push_back(ch);
            if (sweep && (ch == wrap || (ch == 7 && pend))) begin
                ch = 0;
                pend = 1'b0;
            end else if (sweep) begin
                ch++;
            end
        end
    endtask
    task automatic waitFor(input bit onEmpty);
        int n;
        n = 0;
        @(posedge mclk);
        while ((onEmpty ? expQ.size() != 0 : seqComplete !== 1'b1) && n < 600) begin
            @(posedge mclk);
            n++;
        end
        chk8(8'(n < 600), 8'h01);
        if (!onEmpty) chk8(8'(expQ.size()), 8'h00);
    endtask

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            close_out();
        end
    end
    always @(posedge mclk) begin : mon
        logic [3:0] e;
        if (convReq.start === 1'b1 && expQ.size() == 0) begin
            chkReq(convReq, 6'h00);
        end else if (convReq.start === 1'b1) begin
            e = 4'(expQ.pop_front());
            chkReq(convReq, {1'b1, expSpecial, e});
        end
    end

    // ----------------------------------------
    // Stimulus
    // ----------------------------------------
    initial begin
        reset = 1'b1;
        {regWrite, regRead, extTrigger, expSpecial} = 4'h0;
        regAddr = 8'h00;
        regWrData = 8'h00;
        delay = 4'h2;
        mismatches = 0;
        check_count = 0;
        cycles = 0;
        seed = 32'h65cf;
        repeat (3) @(posedge mclk);
        reset <= 1'b0;
        rdReg(ASC_ADDR_SEQ_CTRL, ASC_CTRL_RESET);
        rdReg(ASC_ADDR_ROLLOVER, 8'h0F);
        // Read data must not linger past its one cycle
        @(posedge mclk);
        #1 chk8(regRdData, 8'h00);
        rdReg(ASC_ADDR_SEQ_LEN, 8'h04);
        rdReg(ASC_ADDR_TRIG, 8'h00);
        rdReg(ASC_ADDR_STATUS, 8'h00);
        rdReg(8'h07, 8'h00);
        @(posedge mclk);
        #1 chk8(regRdData, 8'h00);
        for (int k = 0; k < 16; k++) begin
            w = $random(seed) & 15;
            l = $random(seed) & 15;
            c = 8'($random(seed)) & 8'hD7;
            delay <= 4'(($random(seed) & 7) + 1);
            wrReg(ASC_ADDR_ROLLOVER, 8'(w));
            wrReg(ASC_ADDR_SEQ_LEN, 8'(l));
            expSpecial = c[6];
            pushSeq(int'(c[3:0]), w, l, c[4]);
            wrReg(ASC_ADDR_SEQ_CTRL, c);
            waitFor(1'b0);
            #1 chk8({6'h00, seqActive, seqComplete}, 8'h00);
            rdReg(ASC_ADDR_SEQ_CTRL, c);
        end
        // Abort in mid-sequence while the core is still busy
        delay <= 4'hC;
        expSpecial = 1'b0;
        wrReg(ASC_ADDR_ROLLOVER, 8'h0F);
        wrReg(ASC_ADDR_SEQ_LEN, 8'h04);
        pushSeq(2, 15, 4, 1'b1);
        wrReg(ASC_ADDR_SEQ_CTRL, 8'h12);
        repeat (3) @(posedge mclk);
        chk8(8'(expQ.size()), 8'h03);
        expQ.delete();
        pushSeq(5, 15, 4, 1'b0);
        wrReg(ASC_ADDR_SEQ_CTRL, 8'h05);
        waitFor(1'b0);
        // Continuous sweeps, then a single-mode write cuts them
        delay <= 4'h5;
        wrReg(ASC_ADDR_SEQ_LEN, 8'h02);
        repeat (3) pushSeq(6, 15, 2, 1'b1);
        wrReg(ASC_ADDR_SEQ_CTRL, 8'h36);
        waitFor(1'b1);
        #1 chk8({7'h00, seqActive}, 8'h01);
        pushSeq(1, 15, 2, 1'b0);
        wrReg(ASC_ADDR_SEQ_CTRL, 8'h01);
        waitFor(1'b0);
        // Armed by one write; each trigger gives one sequence
        wrReg(ASC_ADDR_TRIG, 8'h01);
        wrReg(ASC_ADDR_SEQ_CTRL, 8'h23);
        repeat (20) @(posedge mclk);
        for (int t = 0; t < 2; t++) begin
            pushSeq(3, 15, 2, 1'b0);
            @(posedge mclk);
            extTrigger <= 1'b1;
            repeat (3) @(posedge mclk);
            extTrigger <= 1'b0;
            waitFor(1'b0);
            #1 chk8({7'h00, seqActive}, 8'h00);
            repeat (20) @(posedge mclk);
        end
        close_out();
    end
endmodule // asc_seq_start_tb_top
`default_nettype wire
